/* hdl/clmr_regs.sv */
// Strap, lock and mode register bank behind the indexed CRT port.
//
// Overview of operation
// - Reset captures pixel pins 7:0 into low strap.
// - Reset captures pixel pins 15:8 into high strap.
// - Bus select bits are read only.
// - Bus select: 01 local bus, 10 PCI.
// - Memory timing: 00 EDO1, 10 EDO2, 11 page.
// - Memory size: 000 4M, 100 2M, 110 1M.
// - BIOS enable gates BIOS; size bit picks 64K/32K.
// - Chip enable low: respond to BIOS only.
// - Palette write snoop gates claim and ready.
// - Key 01xx10xx unlocks extended register set.
// - Key 101xxxxx unlocks system control registers.
// - Strap bits writable only under key A5.
// - System registers locked at reset until keyed.
// - Alternate refresh count overrides standard count.
// - Top memory: bit 13 picks 32K or 64K.
// - Depth bit selects 4-bit or deep shift mode.
// - Burst disable bit refuses PCI read bursts.
// - FIFO restart count, nine bits; restart enable is low in reset and high from the first edge after it.
// - Interlace bit enables interlace start offset.
// - Enhanced port decoded when enabled; config resets 30.
// - Ready delay bit adds a wait state.
// - Horizontal double bit doubles horizontal timing.
`timescale 1ns/100ps
`default_nettype none
`include "clmr_map.svh"

module clmr_regs
    import clmr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [7:0] reg_index,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] pixel_data_pins,
    input wire logic fifo_fetch_bit8,
    input wire logic bios_cycle,
    input wire logic top_mem_addr13,
    output logic [7:0] reg_rdata,
    output logic vga_ext_unlocked,
    output logic sysctl_unlocked,
    output logic [1:0] host_bus_select,
    output logic [1:0] mem_timing,
    output logic [2:0] mem_size,
    output logic bios_access_enable,
    output logic bios_rom_size,
    output logic chip_enable,
    output logic palette_write_snoop,
    output logic bios_decode_ok,
    output logic alt_refresh_enable,
    output logic [1:0] alt_refresh_count,
    output logic top_mem_enable,
    output logic top_mem_64k,
    output logic deep_pixel_shift_mode,
    output logic read_burst_disable,
    output logic fifo_restart_enable,
    output logic [8:0] fifo_restart_count,
    output logic interlace_enable,
    output logic [7:0] interlace_offset,
    output logic enhanced_port_enable,
    output logic ready_delay_select,
    output logic horizontal_double,
    output logic [7:0] bios_flags
);

    ////////////////////////////////////////////////////////////////////////
    clmr_state_s st_reg;
    clmr_state_s st_next;
    logic vga_ok;
    logic sys_ok;
    logic strap_ok;
    logic vga_ok_next;
    logic sys_ok_next;

    assign vga_ok = (st_reg.vga_key & `CLMR_VGA_KEY_MASK) == `CLMR_VGA_KEY_VAL;
    assign sys_ok = (st_reg.sys_key & `CLMR_SYS_KEY_MASK) == `CLMR_SYS_KEY_VAL;
    assign strap_ok = st_reg.sys_key == `CLMR_STRAP_KEY;
    // Unlock state as it will stand after this edge.
    assign vga_ok_next = (st_next.vga_key & `CLMR_VGA_KEY_MASK) ==
        `CLMR_VGA_KEY_VAL;
    assign sys_ok_next = (st_next.sys_key & `CLMR_SYS_KEY_MASK) ==
        `CLMR_SYS_KEY_VAL;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        st_next.pd_s1 = pixel_data_pins;
        st_next.pd_s2 = st_reg.pd_s1;
        if (st_reg.strap_cnt != 2'h3) begin
            // The synchroniser is cleared by reset, so the straps are
            // reloaded until the pins have passed both of its stages.
            st_next.strap_cnt = st_reg.strap_cnt + 2'h1;
            st_next.strap_lo = st_reg.pd_s2[7:0];
            st_next.strap_hi = st_reg.pd_s2[15:8];
        end
        if (reg_wr) begin
            if (reg_index == `CLMR_IDX_SYS_KEY) begin
                st_next.sys_key = reg_wdata;
            end else if (reg_index == `CLMR_IDX_VGA_KEY) begin
                st_next.vga_key = reg_wdata;
            end else if (reg_index == `CLMR_IDX_STRAP_LO && strap_ok) begin
                st_next.strap_lo = (reg_wdata & `CLMR_STRAP_LO_WMASK) |
                    (st_reg.strap_lo & ~`CLMR_STRAP_LO_WMASK);
            end else if (reg_index == `CLMR_IDX_STRAP_HI && strap_ok) begin
                st_next.strap_hi = reg_wdata & `CLMR_STRAP_HI_WMASK;
            end else if (reg_index == `CLMR_IDX_MISC1 && vga_ok) begin
                st_next.misc1 = reg_wdata & `CLMR_MISC1_WMASK;
            end else if (reg_index == `CLMR_IDX_FIFO_RST && vga_ok) begin
                st_next.fifo_rst = reg_wdata;
            end else if (reg_index == `CLMR_IDX_IL_START && vga_ok) begin
                st_next.il_start = reg_wdata;
            end else if (reg_index == `CLMR_IDX_SYS_CFG && sys_ok) begin
                st_next.sys_cfg = (reg_wdata & `CLMR_SYS_CFG_WMASK) |
                    `CLMR_SYS_CFG_FIXED;
            end else if (reg_index == `CLMR_IDX_BIOS_SCRATCH_FLAGS && sys_ok) begin
                st_next.bios_scratch_flags = reg_wdata;
            end else if (reg_index == `CLMR_IDX_IL_MODE && sys_ok) begin
                st_next.il_mode = reg_wdata & `CLMR_IL_MODE_WMASK;
            end else if (reg_index == `CLMR_IDX_EXTENDED_MODE_CONTROL && sys_ok) begin
                st_next.extended_mode_control = reg_wdata & `CLMR_EXTENDED_MODE_CONTROL_WMASK;
            end
        end
        st_next.rdata = `CLMR_RST_ZERO;
        if (reg_rd) begin
            if (reg_index == `CLMR_IDX_SYS_KEY) begin
                st_next.rdata = st_reg.sys_key;
            end else if (reg_index == `CLMR_IDX_VGA_KEY) begin
                st_next.rdata = st_reg.vga_key;
            end else if (reg_index == `CLMR_IDX_STRAP_LO && vga_ok) begin
                st_next.rdata = st_reg.strap_lo;
            end else if (reg_index == `CLMR_IDX_STRAP_HI && vga_ok) begin
                st_next.rdata = st_reg.strap_hi;
            end else if (reg_index == `CLMR_IDX_MISC1 && vga_ok) begin
                st_next.rdata = st_reg.misc1;
            end else if (reg_index == `CLMR_IDX_FIFO_RST && vga_ok) begin
                st_next.rdata = st_reg.fifo_rst;
            end else if (reg_index == `CLMR_IDX_IL_START && vga_ok) begin
                st_next.rdata = st_reg.il_start;
            end else if (reg_index == `CLMR_IDX_SYS_CFG && sys_ok) begin
                st_next.rdata = st_reg.sys_cfg;
            end else if (reg_index == `CLMR_IDX_BIOS_SCRATCH_FLAGS && sys_ok) begin
                st_next.rdata = st_reg.bios_scratch_flags;
            end else if (reg_index == `CLMR_IDX_IL_MODE && sys_ok) begin
                st_next.rdata = st_reg.il_mode;
            end else if (reg_index == `CLMR_IDX_EXTENDED_MODE_CONTROL && sys_ok) begin
                st_next.rdata = st_reg.extended_mode_control;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
            st_reg.sys_cfg <= `CLMR_RST_SYS_CFG;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoded controls, each registered so every output leaves a flop.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= '0;
            vga_ext_unlocked <= 1'b0;
            sysctl_unlocked <= 1'b0;
            host_bus_select <= '0;
            mem_timing <= '0;
            mem_size <= '0;
            bios_access_enable <= 1'b0;
            bios_rom_size <= 1'b0;
            chip_enable <= 1'b0;
            palette_write_snoop <= 1'b0;
            bios_decode_ok <= 1'b0;
            alt_refresh_enable <= 1'b0;
            alt_refresh_count <= '0;
            top_mem_enable <= 1'b0;
            top_mem_64k <= 1'b0;
            deep_pixel_shift_mode <= 1'b0;
            read_burst_disable <= 1'b0;
            fifo_restart_enable <= 1'b0;
            fifo_restart_count <= '0;
            interlace_enable <= 1'b0;
            interlace_offset <= '0;
            enhanced_port_enable <= 1'b0;
            ready_delay_select <= 1'b0;
            horizontal_double <= 1'b0;
            bios_flags <= '0;
        end else begin
            // Controls follow the next state, so a write taken at one
            // edge shows on the controls from that same edge on.
            reg_rdata <= st_next.rdata;
            vga_ext_unlocked <= vga_ok_next;
            sysctl_unlocked <= sys_ok_next;
            host_bus_select <= st_next.strap_lo[1:0];
            mem_timing <= st_next.strap_lo[3:2];
            mem_size <= st_next.strap_lo[7:5];
            bios_access_enable <= st_next.strap_lo[4];
            bios_rom_size <= st_next.strap_hi[2];
            chip_enable <= st_next.strap_hi[0];
            palette_write_snoop <= st_next.strap_hi[4];
            bios_decode_ok <= bios_cycle && st_next.strap_lo[4];
            alt_refresh_enable <= st_next.misc1[2];
            alt_refresh_count <= st_next.misc1[1:0];
            top_mem_enable <= st_next.misc1[3];
            top_mem_64k <= st_next.misc1[3] && top_mem_addr13;
            deep_pixel_shift_mode <= st_next.misc1[4];
            read_burst_disable <= st_next.misc1[7];
            fifo_restart_enable <= 1'b1;
            fifo_restart_count <= {fifo_fetch_bit8, st_next.fifo_rst};
            interlace_enable <= st_next.il_mode[5];
            interlace_offset <= st_next.il_start;
            enhanced_port_enable <= st_next.sys_cfg[0];
            ready_delay_select <= st_next.sys_cfg[4];
            horizontal_double <= st_next.extended_mode_control[7];
            bios_flags <= st_next.bios_scratch_flags;
        end
    end

endmodule
`default_nettype wire

/* hdl/clmr_map.svh */
// Register indices, write masks, field codes, keys and reset values of the bank.
`ifndef CLMR_MAP_SVH
`define CLMR_MAP_SVH
`define CLMR_IDX_STRAP_LO 8'h36
`define CLMR_IDX_STRAP_HI 8'h37
`define CLMR_IDX_VGA_KEY 8'h38
`define CLMR_IDX_SYS_KEY 8'h39
`define CLMR_IDX_MISC1 8'h3A
`define CLMR_IDX_FIFO_RST 8'h3B
`define CLMR_IDX_IL_START 8'h3C
`define CLMR_IDX_SYS_CFG 8'h40
`define CLMR_IDX_BIOS_SCRATCH_FLAGS 8'h41
`define CLMR_IDX_IL_MODE 8'h42
`define CLMR_IDX_EXTENDED_MODE_CONTROL 8'h43
`define CLMR_RST_ZERO 8'h00
`define CLMR_RST_SYS_CFG 8'h30
`define CLMR_STRAP_KEY 8'hA5
`define CLMR_VGA_KEY_MASK 8'hCC
`define CLMR_VGA_KEY_VAL 8'h48
`define CLMR_SYS_KEY_MASK 8'hE0
`define CLMR_SYS_KEY_VAL 8'hA0
`define CLMR_STRAP_LO_WMASK 8'hFC
`define CLMR_SYS_CFG_WMASK 8'h11
`define CLMR_SYS_CFG_FIXED 8'h20
`define CLMR_IL_MODE_WMASK 8'h20
`define CLMR_EXTENDED_MODE_CONTROL_WMASK 8'h84
`define CLMR_MISC1_WMASK 8'hBF
`define CLMR_STRAP_HI_WMASK 8'h1D
`define CLMR_BUS_VL 2'h1
`define CLMR_BUS_PCI 2'h2
`define CLMR_MEM_EDO1 2'h0
`define CLMR_MEM_EDO2 2'h2
`define CLMR_MEM_FPM 2'h3
`define CLMR_SIZE_4M 3'h0
`define CLMR_SIZE_2M 3'h4
`define CLMR_SIZE_1M 3'h6
`endif

/* hdl/clmr_pkg.sv */
// Types of the configuration, lock and mode register bank.
package clmr_pkg;
    typedef struct packed {
        logic [7:0] strap_lo;
        logic [7:0] strap_hi;
        logic [7:0] vga_key;
        logic [7:0] sys_key;
        logic [7:0] misc1;
        logic [7:0] fifo_rst;
        logic [7:0] il_start;
        logic [7:0] sys_cfg;
        logic [7:0] bios_scratch_flags;
        logic [7:0] il_mode;
        logic [7:0] extended_mode_control;
        logic [7:0] rdata;
        logic [15:0] pd_s1;
        logic [15:0] pd_s2;
        logic [1:0] strap_cnt;
    } clmr_state_s;
endpackage

/* testbench/clmr_props.sv */
// Concurrent checks on the ports of the register bank.
`timescale 1ns/100ps
`default_nettype none
module clmr_props (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [7:0] reg_index,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic vga_ext_unlocked,
    input wire logic sysctl_unlocked,
    input wire logic [1:0] host_bus_select,
    input wire logic chip_enable,
    input wire logic [1:0] alt_refresh_count,
    input wire logic read_burst_disable,
    input wire logic enhanced_port_enable,
    input wire logic ready_delay_select,
    input wire logic interlace_enable
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic [2:0] age_reg;
    logic [7:0] wd_reg;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b)
            age_reg <= 3'h0;
        else if (age_reg != 3'h7)
            age_reg <= age_reg + 3'h1;
    end
    always_ff @(posedge clk_sys) begin
        wd_reg <= reg_wdata;
    end
    chk_vga_key: assert property (
        reg_wr && reg_index == 8'h38 |=>
        vga_ext_unlocked == ((wd_reg & 8'hCC) == 8'h48))
        else $error("extended unlock disagrees with key");
    chk_sys_key: assert property (
        reg_wr && reg_index == 8'h39 |=>
        sysctl_unlocked == (wd_reg[7:5] == 3'h5))
        else $error("system unlock disagrees with key");
    chk_cfg_lock: assert property (
        reg_rd && reg_index == 8'h40 && !sysctl_unlocked |=> reg_rdata == 8'h00)
        else $error("locked config read not zero");
    chk_cfg_read: assert property (
        reg_rd && reg_index == 8'h40 && sysctl_unlocked |=> reg_rdata ==
        {3'h1, $past(ready_delay_select), 3'h0, $past(enhanced_port_enable)})
        else $error("config read wrong");
    chk_cfg_write: assert property (
        reg_wr && reg_index == 8'h40 && sysctl_unlocked |=>
        ready_delay_select == wd_reg[4] && enhanced_port_enable == wd_reg[0])
        else $error("config write not applied");
    chk_bus_fixed: assert property (
        age_reg == 3'h7 |-> $stable(host_bus_select))
        else $error("bus select changed");
    chk_strap_guard: assert property (
        reg_wr && reg_index == 8'h37 && !sysctl_unlocked && age_reg == 3'h7
        |=> $stable(chip_enable))
        else $error("strap written without key");
    chk_refresh_wr: assert property (
        reg_wr && reg_index == 8'h3A && vga_ext_unlocked |=>
        alt_refresh_count == wd_reg[1:0] && read_burst_disable == wd_reg[7])
        else $error("misc write not applied");
    chk_intl_guard: assert property (
        reg_wr && reg_index == 8'h42 && !sysctl_unlocked |=>
        $stable(interlace_enable))
        else $error("mode written while locked");
    cover property (vga_ext_unlocked && sysctl_unlocked);
    cover property (reg_wr && reg_index == 8'h36 && sysctl_unlocked);
    cover property (reg_rd && reg_index == 8'h3D);
endmodule
bind clmr_regs clmr_props u_clmr_props (.clk_sys, .rst_b, .reg_index,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .vga_ext_unlocked,
    .sysctl_unlocked, .host_bus_select, .chip_enable, .alt_refresh_count,
    .read_burst_disable, .enhanced_port_enable, .ready_delay_select,
    .interlace_enable);
`default_nettype wire

/* testbench/clmr_host.sv */
// Host model that drives the indexed register port.
`timescale 1ns/100ps
`default_nettype none
module clmr_host (
    input wire logic clk_sys,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_index,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    initial begin
        reg_index = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task wr(input logic [7:0] i, input logic [7:0] d);
        @(posedge clk_sys);
        reg_index <= i;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task rd(input logic [7:0] i, output logic [7:0] d);
        @(posedge clk_sys);
        reg_index <= i;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

/* testbench/clmr_regs_test.sv */
// Self-checking bench for the strap, lock and mode register bank.
`timescale 1ns/100ps
`default_nettype none
module clmr_regs_test;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic bit8 = 1'b0;
    logic bcyc = 1'b0;
    logic a13 = 1'b0;
    logic [15:0] pins = 16'h0000;
    logic [31:0] r;
    logic [31:0] s = 32'h000141D6;
    logic [7:0] idx;
    logic [7:0] m [256];
    logic [7:0] reg_index, reg_wdata, reg_rdata, interlace_offset, bios_flags;
    logic [8:0] fifo_restart_count;
    logic [2:0] mem_size;
    logic [1:0] host_bus_select, mem_timing, alt_refresh_count;
    logic reg_wr, reg_rd, vga_ext_unlocked, sysctl_unlocked, chip_enable;
    logic bios_access_enable, bios_rom_size, palette_write_snoop;
    logic bios_decode_ok, alt_refresh_enable, top_mem_enable, top_mem_64k;
    logic deep_pixel_shift_mode, read_burst_disable, fifo_restart_enable;
    logic interlace_enable, enhanced_port_enable, ready_delay_select;
    logic horizontal_double;
    int n_errors = 0;
    int comparisons = 0;
    int cyc = 0;
    logic [7:0] lo_t [3] = '{8'h01, 8'h8A, 8'hCD};
    wire [8:0] lo_w = {1'b0, mem_size, bios_access_enable, mem_timing,
        host_bus_select};
    wire [8:0] hi_w = {6'h00, palette_write_snoop, bios_rom_size, chip_enable};
    wire [8:0] mi_w = {3'h0, read_burst_disable, deep_pixel_shift_mode,
        top_mem_enable, alt_refresh_enable, alt_refresh_count};
    wire [8:0] mo_w = {3'h0, ready_delay_select, enhanced_port_enable,
        horizontal_double, interlace_enable, sysctl_unlocked, vga_ext_unlocked};
    clmr_host u_clmr_host (.clk_sys, .reg_rdata, .reg_index, .reg_wdata,
        .reg_wr, .reg_rd);
    clmr_regs u_clmr_regs (.clk_sys, .rst_b, .reg_index, .reg_wdata, .reg_wr,
        .reg_rd, .pixel_data_pins(pins), .fifo_fetch_bit8(bit8),
        .bios_cycle(bcyc), .top_mem_addr13(a13), .reg_rdata, .vga_ext_unlocked,
        .sysctl_unlocked, .host_bus_select, .mem_timing, .mem_size,
        .bios_access_enable, .bios_rom_size, .chip_enable, .palette_write_snoop,
        .bios_decode_ok, .alt_refresh_enable, .alt_refresh_count,
        .top_mem_enable, .top_mem_64k, .deep_pixel_shift_mode,
        .read_burst_disable, .fifo_restart_enable, .fifo_restart_count,
        .interlace_enable, .interlace_offset, .enhanced_port_enable,
        .ready_delay_select, .horizontal_double, .bios_flags);
    always #10 clk_sys = ~clk_sys;
    function logic [31:0] rnd();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    function logic ok(logic [7:0] i, logic w);
        logic v;
        v = (m[8'h38] & 8'hCC) == 8'h48;
        if (i == 8'h36 || i == 8'h37)
            return w ? m[8'h39] == 8'hA5 : v;
        if (i >= 8'h3A && i <= 8'h3C)
            return v;
        return m[8'h39][7:5] == 3'h5 && i >= 8'h40 && i <= 8'h43;
    endfunction
    function logic [7:0] wm(logic [7:0] i);
        case (i)
            8'h36: return 8'hFC;
            8'h37: return 8'h1D;
            8'h3A: return 8'hBF;
            8'h40: return 8'h11;
            8'h42: return 8'h20;
            8'h43: return 8'h84;
            default: return 8'hFF;
        endcase
    endfunction
    task print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task ck(string n, logic [8:0] seen, logic [8:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task jig();
        @(posedge clk_sys);
        r = rnd();
        {bit8, bcyc, a13} <= r[2:0];
    endtask
    task mwr(logic [7:0] i, logic [7:0] d);
        jig();
        u_clmr_host.wr(i, d);
        // Reserved bits of the high strap read back as zero once rewritten.
        if (ok(i, 1'b1))
            m[i] = (m[i] & ~wm(i) & {8{i != 8'h37}}) | (d & wm(i));
    endtask
    task mrd(logic [7:0] i);
        logic [7:0] d;
        jig();
        u_clmr_host.rd(i, d);
        ck("read data", {1'b0, d}, {1'b0, ok(i, 1'b0) ? m[i] : 8'h00});
    endtask
    task key(logic [7:0] i, logic [7:0] d);
        u_clmr_host.wr(i, d);
        m[i] = d;
    endtask
    task outs();
        @(negedge clk_sys);
        ck("strap low", lo_w, {1'b0, m[8'h36]});
        ck("strap high", hi_w,
            {6'h00, m[8'h37][4], m[8'h37][2], m[8'h37][0]});
        ck("misc", mi_w, {3'h0, m[8'h3A][7], m[8'h3A][4:0]});
        ck("modes", mo_w, {3'h0, m[8'h40][4], m[8'h40][0], m[8'h43][7],
            m[8'h42][5], m[8'h39][7:5] == 3'h5, ok(8'h3A, 1'b0)});
        ck("fifo count", fifo_restart_count, {bit8, m[8'h3B]});
        ck("offset", {1'b0, interlace_offset}, {1'b0, m[8'h3C]});
        ck("flags", {fifo_restart_enable, bios_flags},
            {1'b1, m[8'h41]});
        ck("bios decode", {8'h00, bios_decode_ok},
            {8'h00, bcyc & m[8'h36][4]});
        ck("top window", {8'h00, top_mem_64k},
            {8'h00, a13 & m[8'h3A][3]});
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 6000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        for (int k = 0; k < 3; k++) begin
            r = rnd();
            @(posedge clk_sys);
            rst_b <= 1'b0;
            pins <= {r[15:8], lo_t[k] | (r[7:0] & 8'h10)};
            repeat (16) @(posedge clk_sys);
            rst_b <= 1'b1;
            foreach (m[i]) m[i] = 8'h00;
            m[8'h36] = pins[7:0];
            m[8'h37] = pins[15:8];
            m[8'h40] = 8'h30;
            repeat (4) @(posedge clk_sys);
            outs();
            mrd(8'h40);
            mwr(8'h36, r[23:16]);
            key(8'h38, 8'h48 | (r[31:24] & 8'h33));
            mrd(8'h36);
            key(8'h39, 8'hA5);
            for (int j = 0; j < 30; j++) begin
                r = rnd();
                idx = 8'h36 + ({4'h0, r[7:4]} % 8'h0E);
                if (idx == 8'h39)
                    key(8'h39, j[2] ? 8'hA5 : r[15:8]);
                else if (r[8] && idx != 8'h38)
                    mwr(idx, r[23:16]);
                else
                    mrd(idx == 8'h38 ? 8'h43 : idx);
                outs();
            end
            key(8'h39, 8'h20);
            mwr(8'h40, 8'hFF);
            mrd(8'h40);
            key(8'h38, 8'h00);
            mrd(8'h3A);
            outs();
            $display("reset pass %0d done", k);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
